// ### logic/flash_status_pkg.sv
/*
  Constants and types for the serial flash status register block.
  Assumes a 1 MB array split into 16 blocks of 64 KB.
*/
package flash_status_pkg;
  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] READ_STATUS_CMD         = 8'h05;
  localparam logic [7:0] READ_SUSPEND_STATUS_CMD = 8'h09;
  localparam logic [7:0] READ_FOURTH_STATUS_CMD  = 8'h85;
  localparam logic [7:0] WRITE_STATUS_CMD        = 8'h01;
  localparam logic [7:0] WRITE_ENABLE_CMD        = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD       = 8'h04;
  localparam logic [7:0] QUAD_COMMAND_ENTRY      = 8'h38;
  localparam logic [7:0] QUAD_COMMAND_EXIT       = 8'hFF;
  // ----------------------------------------
  // Primary status fields, normal layout
  // ----------------------------------------
  localparam int BUSY_FLAG_POS  = 0;
  localparam int WR_ENABLE_POS  = 1;
  localparam int BP_LO_POS      = 2;
  localparam int BP_HI_POS      = 4;
  localparam int TOP_BOTTOM_POS = 5;
  localparam int GRAN_POS       = 6;
  localparam int GUARD_POS      = 7;
  // OTP layout
  localparam int LOCK_TWO_POS   = 1;
  localparam int LOCK_ONE_POS   = 2;
  localparam int BOOT_LOCK_POS  = 3;
  localparam int LOCK_ZERO_POS  = 7;
  // Suspend status layout
  localparam int ERASE_SUSP_POS = 2;
  localparam int PROG_SUSP_POS  = 3;
  // ----------------------------------------
  // Reset values and timing
  // ----------------------------------------
  localparam logic [7:2] NV_RESET  = 6'h00;
  localparam logic [3:0] OTP_RESET = 4'h0;
  localparam int CLK_PERIOD_NS = 8;
  localparam int WSR_TIME_NS   = 10000;
  localparam int WSR_CYCLES    = (WSR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ADDR_W        = 20;
  // ----------------------------------------
  // Array operation request
  // ----------------------------------------
  typedef enum logic [1:0] {
    OP_PROGRAM = 2'h0,
    OP_SECTOR  = 2'h1,
    OP_BLOCK   = 2'h2,
    OP_CHIP    = 2'h3
  } array_op_t;
  typedef struct packed {
    array_op_t         op;
    logic              secure;
    logic [1:0]        sec_id;
    logic [ADDR_W-1:0] addr;
  } array_req_t;
endpackage

// ### logic/flash_status_regs.sv
/*
  Status register bank of a serial flash: serial status reads, status
  write, write enable latch, block and boot protection, suspend flags.
  Assumes the serial clock, chip select and data pins come from a host
  far slower than core_clk_in; array engine signals are synchronous.
*/
module flash_status_regs #(
  parameter int WSR_CYCLES_P = flash_status_pkg::WSR_CYCLES
) (
  input  wire logic                        core_clk_in,
  input  wire logic                        rstn_in,
  input  wire logic                        sclk_in,
  input  wire logic                        cs_n_in,
  input  wire logic [3:0]                  dq_in,
  output logic      [3:0]                  dq_out,
  output logic      [3:0]                  dq_oe_out,
  input  wire logic                        array_busy_in,
  input  wire logic                        array_req_valid_in,
  input  wire flash_status_pkg::array_req_t array_req_in,
  output logic                             array_go_out,
  output logic                             array_refuse_out,
  input  wire logic                        erase_suspend_in,
  input  wire logic                        program_suspend_in,
  input  wire logic                        resume_in,
  input  wire logic                        otp_mode_in,
  input  wire logic                        complement_in,
  input  wire logic [7:0]                  fourth_status_in,
  output logic                             quad_mode_out,
  output logic                             hw_protect_out
);
  import flash_status_pkg::*;

  localparam int CW = $clog2(WSR_CYCLES_P + 1);

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CMD   = 5'b00010,
    ST_WDATA = 5'b00100,
    ST_READ  = 5'b01000,
    ST_HOLD  = 5'b10000
  } ser_state_t;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [1:0] sclk_s_q, cs_s_q;
  logic [3:0] dq_s1_q, dq_s2_q;
  logic       sclk_d_q, cs_d_q;

  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sclk_s_q <= 2'h0;
      cs_s_q   <= 2'h3;
      dq_s1_q  <= 4'hF;
      dq_s2_q  <= 4'hF;
      sclk_d_q <= 1'b0;
      cs_d_q   <= 1'b1;
    end
    else
    begin
      sclk_s_q <= {sclk_s_q[0], sclk_in};
      cs_s_q   <= {cs_s_q[0], cs_n_in};
      dq_s1_q  <= dq_in;
      dq_s2_q  <= dq_s1_q;
      sclk_d_q <= sclk_s_q[1];
      cs_d_q   <= cs_s_q[1];
    end
  end

  logic sck_rise, sck_fall, cs_rise, selected;
  assign sck_rise = sclk_s_q[1] & ~sclk_d_q;
  assign sck_fall = ~sclk_s_q[1] & sclk_d_q;
  assign cs_rise  = cs_s_q[1] & ~cs_d_q;
  assign selected = ~cs_s_q[1];

  // ----------------------------------------
  // State
  // ----------------------------------------
  ser_state_t    state_q, state_d;
  logic [2:0]    icnt_q, icnt_d, ocnt_q, ocnt_d;
  logic [7:0]    sh_in_q, sh_in_d, sh_out_q, sh_out_d;
  logic [7:0]    cmd_q, cmd_d, wdata_q, wdata_d;
  logic [3:0]    dq_q, dq_d;
  logic          quad_q, quad_d, wr_en_q, wr_en_d;
  logic [7:2]    nv_q, nv_d;
  logic [3:0]    otp_q, otp_d;
  logic          wsr_busy_q, wsr_busy_d;
  logic [CW-1:0] wsr_cnt_q, wsr_cnt_d;
  logic          esusp_q, esusp_d, psusp_q, psusp_d;
  logic          go_q, go_d, refuse_q, refuse_d;
  logic          busy_now, guard_active, wsr_start;
  logic [7:0]    primary, suspend, in_byte;

  // ----------------------------------------
  // Protection decode
  // ----------------------------------------
  function automatic logic [4:0] bp_blocks(logic [2:0] bp);
    if (bp == 3'h0)
      return 5'h00;
    else if (bp > 3'h5)
      return 5'h10;
    else
      return 5'(5'h01 << (bp - 3'h1));
  endfunction

  function automatic logic blocked(array_req_t r, logic [7:2] nv, logic [3:0] otp,
                                   logic comp);
    logic [4:0] n;
    logic [4:0] blk;
    logic       hit, boot, bot, boot_en;
    n       = bp_blocks(nv[BP_HI_POS:BP_LO_POS]);
    blk     = {1'b0, r.addr[ADDR_W-1:16]};
    bot     = nv[TOP_BOTTOM_POS];
    boot_en = otp[BOOT_LOCK_POS-1];
    hit     = (bot ? (blk < n) : (blk >= 5'h10 - n)) ^ comp;
    boot    = boot_en & ((nv[GRAN_POS] && r.op != OP_BLOCK)
              ? (r.addr[ADDR_W-1:12] == (bot ? 8'h00 : 8'hFF))
              : (blk[3:0] == (bot ? 4'h0 : 4'hF)));
    if (r.secure)
      return (r.sec_id == 2'h0) ? otp[3] : (r.sec_id == 2'h1) ? otp[1] : otp[0];
    if (r.op == OP_CHIP)
      return boot_en | ((n != 5'h00) ^ comp);
    return hit | boot;
  endfunction

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  always_comb
  begin
    busy_now     = wsr_busy_q | array_busy_in;
    guard_active = nv_q[GUARD_POS] & ~dq_s2_q[2] & ~quad_q;
    if (otp_mode_in)
      primary = {otp_q[3], 3'h0, otp_q[2], otp_q[1], otp_q[0], busy_now};
    else
      primary = {nv_q, wr_en_q, busy_now};
    suspend = 8'h00;
    suspend[BUSY_FLAG_POS]  = busy_now;
    suspend[ERASE_SUSP_POS] = esusp_q;
    suspend[PROG_SUSP_POS]  = psusp_q;
  end

  assign in_byte = quad_q ? {sh_in_q[3:0], dq_s2_q} : {sh_in_q[6:0], dq_s2_q[0]};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] word;
    logic       done;
    word       = 8'h00;
    done       = (icnt_q == (quad_q ? 3'h4 : 3'h7));
    state_d    = state_q;
    icnt_d     = icnt_q;
    ocnt_d     = ocnt_q;
    sh_in_d    = sh_in_q;
    sh_out_d   = sh_out_q;
    cmd_d      = cmd_q;
    wdata_d    = wdata_q;
    dq_d       = dq_q;
    quad_d     = quad_q;
    wr_en_d    = wr_en_q;
    nv_d       = nv_q;
    otp_d      = otp_q;
    wsr_busy_d = wsr_busy_q;
    wsr_cnt_d  = wsr_cnt_q;
    wsr_start  = 1'b0;
    go_d       = 1'b0;
    refuse_d   = 1'b0;
    if (!selected)
      state_d = ST_IDLE;
    else if (state_q == ST_IDLE)
    begin
      state_d = ST_CMD;
      icnt_d  = 3'h0;
      ocnt_d  = 3'h0;
    end
    else if (sck_rise)
    begin
      sh_in_d = in_byte;
      icnt_d  = icnt_q + (quad_q ? 3'h4 : 3'h1);
      case (state_q)
        ST_CMD:
          if (done)
          begin
            cmd_d = in_byte;
            case (in_byte)
              READ_STATUS_CMD, READ_SUSPEND_STATUS_CMD, READ_FOURTH_STATUS_CMD:
                state_d = ST_READ;
              WRITE_STATUS_CMD:
                state_d = ST_WDATA;
              default:
                state_d = ST_HOLD;
            endcase
          end
        ST_WDATA:
          if (done)
          begin
            wdata_d = in_byte;
            state_d = ST_HOLD;
          end
        ST_HOLD:
          cmd_d = 8'h00;
        default:
          ;
      endcase
    end
    else if (sck_fall && state_q == ST_READ)
    begin
      case (cmd_q)
        READ_STATUS_CMD:
          word = (ocnt_q == 3'h0) ? primary : sh_out_q;
        READ_SUSPEND_STATUS_CMD:
          word = (ocnt_q == 3'h0) ? suspend : sh_out_q;
        default:
          word = (ocnt_q == 3'h0) ? fourth_status_in : sh_out_q;
      endcase
      dq_d     = quad_q ? word[7:4] : {2'h0, word[7], 1'b0};
      sh_out_d = quad_q ? {word[3:0], 4'h0} : {word[6:0], 1'b0};
      ocnt_d   = ocnt_q + (quad_q ? 3'h4 : 3'h1);
    end
    if (cs_rise && state_q == ST_HOLD)
    begin
      case (cmd_q)
        WRITE_ENABLE_CMD:
          wr_en_d = 1'b1;
        WRITE_DISABLE_CMD:
          wr_en_d = 1'b0;
        QUAD_COMMAND_ENTRY:
          quad_d = 1'b1;
        QUAD_COMMAND_EXIT:
          quad_d = quad_q ? 1'b0 : quad_q;
        WRITE_STATUS_CMD:
          if (wr_en_q && !guard_active && !busy_now)
          begin
            wsr_start = 1'b1;
            if (otp_mode_in)
              otp_d = otp_q | {wdata_q[LOCK_ZERO_POS], wdata_q[BOOT_LOCK_POS],
                               wdata_q[LOCK_ONE_POS], wdata_q[LOCK_TWO_POS]};
            else
              nv_d = wdata_q[7:2];
          end
        default:
          ;
      endcase
    end
    if (wsr_start)
    begin
      wsr_busy_d = 1'b1;
      wsr_cnt_d  = CW'(WSR_CYCLES_P - 1);
    end
    else if (wsr_busy_q)
    begin
      if (wsr_cnt_q == '0)
      begin
        wsr_busy_d = 1'b0;
        // A write enable landing in the same cycle wins
        wr_en_d    = cs_rise && state_q == ST_HOLD && cmd_q == WRITE_ENABLE_CMD;
      end
      else
        wsr_cnt_d = wsr_cnt_q - CW'(1);
    end
    if (array_req_valid_in)
    begin
      if (wr_en_q && !busy_now && !blocked(array_req_in, nv_q, otp_q, complement_in))
      begin
        go_d    = 1'b1;
        wr_en_d = cs_rise && state_q == ST_HOLD && cmd_q == WRITE_ENABLE_CMD;
      end
      else
        refuse_d = 1'b1;
    end
  end

  always_comb
  begin
    esusp_d = erase_suspend_in ? 1'b1 : (resume_in ? 1'b0 : esusp_q);
    psusp_d = program_suspend_in ? 1'b1 : (resume_in ? 1'b0 : psusp_q);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q    <= ST_IDLE;
      icnt_q     <= 3'h0;
      ocnt_q     <= 3'h0;
      sh_in_q    <= 8'h00;
      sh_out_q   <= 8'h00;
      cmd_q      <= 8'h00;
      wdata_q    <= 8'h00;
      dq_q       <= 4'h0;
      quad_q     <= 1'b0;
      wr_en_q    <= 1'b0;
      nv_q       <= NV_RESET;
      otp_q      <= OTP_RESET;
      wsr_busy_q <= 1'b0;
      wsr_cnt_q  <= '0;
      esusp_q    <= 1'b0;
      psusp_q    <= 1'b0;
      go_q       <= 1'b0;
      refuse_q   <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      icnt_q     <= icnt_d;
      ocnt_q     <= ocnt_d;
      sh_in_q    <= sh_in_d;
      sh_out_q   <= sh_out_d;
      cmd_q      <= cmd_d;
      wdata_q    <= wdata_d;
      dq_q       <= dq_d;
      quad_q     <= quad_d;
      wr_en_q    <= wr_en_d;
      nv_q       <= nv_d;
      otp_q      <= otp_d;
      wsr_busy_q <= wsr_busy_d;
      wsr_cnt_q  <= wsr_cnt_d;
      esusp_q    <= esusp_d;
      psusp_q    <= psusp_d;
      go_q       <= go_d;
      refuse_q   <= refuse_d;
    end
  end

  assign dq_out           = dq_q;
  assign dq_oe_out        = (state_q == ST_READ) ? (quad_q ? 4'hF : 4'h2) : 4'h0;
  assign array_go_out     = go_q;
  assign array_refuse_out = refuse_q;
  assign quad_mode_out    = quad_q;
  assign hw_protect_out   = guard_active;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  chk_busy_mirror: assert property (suspend[0] == primary[0])
    else $error("suspend busy bit differs from primary busy");
  chk_susp_reserved: assert property ((suspend & 8'h92) == 8'h00)
    else $error("reserved suspend bit set");
  chk_write_gate: assert property (array_go_out |-> $past(wr_en_q))
    else $error("array op accepted without write enable");
  chk_guard_hold: assert property (guard_active && !otp_mode_in |=> $stable(nv_q))
    else $error("protect bits changed in hardware protection");
  chk_chip_lock: assert property (
    array_req_valid_in && array_req_in.op == OP_CHIP && otp_q[2] |=> array_refuse_out)
    else $error("chip erase accepted with boot lock");
  chk_wsr_busy: assert property (wsr_start |=> wsr_busy_q[*8])
    else $error("status write cycle ended early");
  chk_erase_susp: assert property (erase_suspend_in |=> esusp_q ##0 suspend[2])
    else $error("erase suspend flag not set");
  chk_prog_resume: assert property (
    resume_in && !program_suspend_in |=> !psusp_q)
    else $error("program suspend flag not cleared");
  chk_otp_once: assert property ((otp_q & $past(otp_q)) == $past(otp_q))
    else $error("security lock bit cleared");

  cov_read_primary: cover property (state_q == ST_READ && cmd_q == READ_STATUS_CMD);
  cov_quad_read: cover property (quad_q && state_q == ST_READ);
  cov_wsr: cover property (wsr_start ##1 wsr_busy_q);
  cov_refuse: cover property (array_refuse_out);
endmodule

// ### bench/flash_host_model.sv
/*
  Host serial controller model driving the flash status block, mode 0.
  Assumes the bench resolves the pins and pulls released lines high, except DQ2, which follows wp_n.
*/
module flash_host_model
  import flash_status_pkg::*;
(
  input  wire logic [3:0] pin_in,
  output logic            sclk_out,
  output logic            cs_n_out,
  output logic      [3:0] dq_out,
  output logic      [3:0] dq_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic quad_q;
  initial
  begin
    sclk_out  = 1'b0;
    cs_n_out  = 1'b1;
    dq_out    = 4'hF;
    dq_oe_out = 4'h0;
    quad_q    = 1'b0;
  end
  // ----------------------------------------
  // Frame tasks
  // ----------------------------------------
  // Data set in low phase, sampled at rise
  task automatic unit(input logic [3:0] d, output logic [3:0] q);
    dq_out = quad_q ? d : {3'h7, d[0]};
    #40 sclk_out = 1'b1;
    q = pin_in;
    #40 sclk_out = 1'b0;
  endtask
  task automatic send(input logic [7:0] b);
    logic [3:0] q;
    if (quad_q)
    begin
      unit(b[7:4], q);
      unit(b[3:0], q);
    end
    else
      for (int i = 7; i >= 0; i--)
        unit({3'h0, b[i]}, q);
  endtask
  task automatic xact(input logic [7:0] cmd, input logic wr, input logic [7:0] wd,
                      input int nr, output logic [15:0] rd);
    logic [3:0] q;
    rd = 16'h0000;
    #3 cs_n_out = 1'b0;
    dq_oe_out = quad_q ? 4'hF : 4'h1;
    #40 send(cmd);
    if (wr)
      send(wd);
    if (nr > 0)
      dq_oe_out = quad_q ? 4'h0 : 4'h1;
    for (int i = 0; i < nr * (quad_q ? 2 : 8); i++)
    begin
      unit(4'hF, q);
      rd = quad_q ? {rd[11:0], q} : {rd[14:0], q[1]};
    end
    #40 cs_n_out = 1'b1;
    dq_oe_out = 4'h0;
    #100;
    if (cmd == QUAD_COMMAND_ENTRY)
      quad_q = 1'b1;
    if (cmd == QUAD_COMMAND_EXIT)
      quad_q = 1'b0;
  endtask
endmodule

// ### bench/tb_flash_status_regs.sv
/*
  Self-checking bench for the flash status register block.
  Assumes a 1 MB array of 64 KB blocks and the host model beside it.
*/
module tb_flash_status_regs import flash_status_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WSR_SIM = 400;
  logic       core_clk, rstn, wp_n, valid, busy, esus, psus, resume, otp, comp;
  logic       sclk, cs_n, go, refuse, quad, hwp;
  logic [7:0] fourth;
  logic [3:0] dut_dq, dut_oe, h_dq, h_oe, pin;
  array_req_t req;
  int         failures, tests_run;
  assign pin = (dut_oe & dut_dq) | (~dut_oe & h_oe & h_dq) | (~dut_oe & ~h_oe & {1'b1, wp_n, 2'h3});
  always #4 core_clk = ~core_clk;
  flash_status_regs #(.WSR_CYCLES_P(WSR_SIM)) i_dut (
    .core_clk_in(core_clk), .rstn_in(rstn), .sclk_in(sclk), .cs_n_in(cs_n),
    .dq_in(pin), .dq_out(dut_dq), .dq_oe_out(dut_oe), .array_busy_in(busy),
    .array_req_valid_in(valid), .array_req_in(req), .array_go_out(go),
    .array_refuse_out(refuse), .erase_suspend_in(esus), .program_suspend_in(psus),
    .resume_in(resume), .otp_mode_in(otp), .complement_in(comp),
    .fourth_status_in(fourth), .quad_mode_out(quad), .hw_protect_out(hwp));
  flash_host_model i_host (.pin_in(pin), .sclk_out(sclk), .cs_n_out(cs_n),
    .dq_out(h_dq), .dq_oe_out(h_oe));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    repeat (4) @(negedge core_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [15:0] r;
    i_host.xact(c, 1'b0, 8'h00, 0, r);
  endtask
  // Two bytes read, the second must repeat the first
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [15:0] r;
    i_host.xact(c, 1'b0, 8'h00, 2, r);
    chk(r, {exp, exp});
  endtask
  task automatic wr(input logic [7:0] v, input logic ok);
    logic [15:0] r;
    cmd(WRITE_ENABLE_CMD);
    i_host.xact(WRITE_STATUS_CMD, 1'b1, v, 0, r);
    i_host.xact(READ_STATUS_CMD, 1'b0, 8'h00, 1, r);
    chk(16'(r[0]), 16'(ok));
    for (int n = 0; n < 10 && r[0] !== 1'b0; n++)
      i_host.xact(READ_STATUS_CMD, 1'b0, 8'h00, 1, r);
    if (r[0] !== 1'b0)
    begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic ask(input logic wren, input array_op_t op, input logic [19:0] a,
                     input logic [2:0] sec, input logic exp);
    if (wren)
      cmd(WRITE_ENABLE_CMD);
    @(negedge core_clk);
    valid = 1'b1;
    req = '{op: op, secure: sec[2], sec_id: sec[1:0], addr: a};
    @(negedge core_clk);
    valid = 1'b0;
    chk({14'h0, go, refuse}, {14'h0, exp, ~exp});
  endtask
  task automatic pulse(input logic [2:0] v);
    @(negedge core_clk);
    {esus, psus, resume} = v;
    @(negedge core_clk);
    {esus, psus, resume} = 3'h0;
  endtask
  task automatic set_level(input logic o, input logic c, input logic w);
    @(negedge core_clk);
    otp = o;
    comp = c;
    wp_n = w;
    repeat (4) @(negedge core_clk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_wel();
    rd(READ_STATUS_CMD, 8'h00);
    rd(READ_SUSPEND_STATUS_CMD, 8'h00);
    rd(READ_FOURTH_STATUS_CMD, 8'h5A);
    ask(1'b0, OP_PROGRAM, 20'h00000, 3'h0, 1'b0);
    cmd(WRITE_ENABLE_CMD);
    rd(READ_STATUS_CMD, 8'h02);
    cmd(WRITE_DISABLE_CMD);
    rd(READ_STATUS_CMD, 8'h00);
  endtask
  task automatic t_busy_suspend();
    logic [15:0] r;
    @(negedge core_clk);
    busy = 1'b1;
    rd(READ_STATUS_CMD, 8'h01);
    rd(READ_SUSPEND_STATUS_CMD, 8'h01);
    pulse(3'b100);
    rd(READ_SUSPEND_STATUS_CMD, 8'h05);
    pulse(3'b010);
    rd(READ_SUSPEND_STATUS_CMD, 8'h0D);
    i_host.xact(READ_SUSPEND_STATUS_CMD, 1'b0, 8'h00, 1, r);
    chk(r & 16'h006D, 16'h000D);
    pulse(3'b001);
    rd(READ_SUSPEND_STATUS_CMD, 8'h01);
    @(negedge core_clk);
    busy = 1'b0;
    rd(READ_SUSPEND_STATUS_CMD, 8'h00);
  endtask
  task automatic t_hw_protect();
    wr(8'hFF, 1'b1);
    rd(READ_STATUS_CMD, 8'hFC);
    set_level(1'b0, 1'b0, 1'b0);
    chk(16'(hwp), 16'h0001);
    wr(8'h00, 1'b0);
    rd(READ_STATUS_CMD, 8'hFE);
    set_level(1'b0, 1'b0, 1'b1);
    wr(8'h00, 1'b1);
    rd(READ_STATUS_CMD, 8'h00);
  endtask
  task automatic t_block_protect();
    wr(8'h04, 1'b1);
    for (int k = 0; k < 4; k++)
      ask(1'b1, array_op_t'(k), 20'hF1000, 3'h0, 1'b0);
    ask(1'b1, OP_PROGRAM, 20'h00000, 3'h0, 1'b1);
    wr(8'h24, 1'b1);
    ask(1'b1, OP_PROGRAM, 20'h00000, 3'h0, 1'b0);
    ask(1'b1, OP_PROGRAM, 20'hF0000, 3'h0, 1'b1);
    wr(8'h00, 1'b1);
    set_level(1'b0, 1'b1, 1'b1);
    ask(1'b1, OP_CHIP, 20'h00000, 3'h0, 1'b0);
    set_level(1'b0, 1'b0, 1'b1);
    ask(1'b1, OP_CHIP, 20'h00000, 3'h0, 1'b1);
  endtask
  task automatic t_boot_otp();
    wr(8'h40, 1'b1);
    set_level(1'b1, 1'b0, 1'b1);
    wr(8'h08, 1'b1);
    rd(READ_STATUS_CMD, 8'h08);
    set_level(1'b0, 1'b0, 1'b1);
    rd(READ_STATUS_CMD, 8'h40);
    ask(1'b1, OP_PROGRAM, 20'hFF000, 3'h0, 1'b0);
    ask(1'b1, OP_PROGRAM, 20'hFE000, 3'h0, 1'b1);
    ask(1'b1, OP_CHIP, 20'h00000, 3'h0, 1'b0);
    set_level(1'b1, 1'b0, 1'b1);
    wr(8'h04, 1'b1);
    rd(READ_STATUS_CMD, 8'h0C);
    ask(1'b1, OP_PROGRAM, 20'h00000, 3'h5, 1'b0);
    ask(1'b1, OP_PROGRAM, 20'h00000, 3'h4, 1'b1);
    wr(8'h00, 1'b1);
    rd(READ_STATUS_CMD, 8'h0C);
    set_level(1'b0, 1'b0, 1'b1);
  endtask
  task automatic t_quad();
    cmd(QUAD_COMMAND_ENTRY);
    chk(16'(quad), 16'h0001);
    rd(READ_STATUS_CMD, 8'h40);
    rd(READ_FOURTH_STATUS_CMD, 8'h5A);
    cmd(QUAD_COMMAND_EXIT);
    chk(16'(quad), 16'h0000);
  endtask
  task automatic t_mid_reset();
    pulse(3'b110);
    do_reset();
    rd(READ_SUSPEND_STATUS_CMD, 8'h00);
  endtask
  initial
  begin
    core_clk = 1'b0;
    rstn = 1'b0;
    {wp_n, valid, busy, esus, psus, resume, otp, comp} = 8'h80;
    fourth = 8'h5A;
    req = '0;
    failures = 0;
    tests_run = 0;
    do_reset();
    t_reset_wel();
    t_busy_suspend();
    t_hw_protect();
    t_block_protect();
    t_boot_otp();
    t_quad();
    t_mid_reset();
    print_verdict();
  end
endmodule
